// file: rtl/jtag_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface jtag_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    modport device (input tck, input tms, input tdi, output tdo);
    modport programmer (output tck, output tms, output tdi, input tdo);
endinterface
`default_nettype wire

// file: rtl/nvm_device_end.sv
// Operation
// - programmer enters key before memory access
// - flash read needs command 3a first
// - word address loaded by 3b, 3c
// - 3d returns addressed flash word
// - page address uses word index zero
// - page shifts out LSB first, whole page
// - first eight page bits are dummy
// - page path one byte longer, bytewise
// - reselect commands before next page
// - chip erase before any eeprom write
// - erase by 1a, polled by 1b
// - eeprom write enabled 4a, high address 4b
// - per byte: 4c address, 4d/4e data
// - 4f writes page, 47 polls
// - programmer repeats per eeprom page
// - no page load for eeprom
// - eeprom read: 5a then 5b address
// - 5d returns addressed eeprom byte
// - no page read for eeprom
// - fuse write: 6a then 6b data
// - fuse bit zero means programmed
// - 6c writes extended fuse, 6d polls
`timescale 1ns/1ns
`default_nettype none
module nvm_stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic full;
    logic empty;

    always_comb begin
        empty = (wr_ptr == rd_ptr);
        full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
        in_ready = !full;
        out_valid = !empty;
        out_data = mem[rd_ptr[AW-1:0]];
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
        end else begin
            if (in_valid && !full) begin
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (out_ready && !empty) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (in_valid && !full && !flush) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

module nvm_device_end #(
    parameter int ERASE_CYCLES = nvm_pkg::ERASE_CYCLES,
    parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    jtag_link_if.device link,
    output logic prog_mode,
    output logic busy,
    output logic [7:0] fuse_programmed
);
    localparam int OW = nvm_pkg::OPCNT_W;
    localparam int ERASE_LAST = ERASE_CYCLES - 1;
    localparam int WRITE_LAST = WRITE_CYCLES - 1;

    logic [15:0] flash [nvm_pkg::FLASH_WORDS];
    logic [7:0] eeprom [nvm_pkg::EE_BYTES];

    logic [2:0] s1, s2;
    logic [1:0] d3;
    logic rise, fall, start, stop, page_out;
    logic [4:0] bitcnt, next_bitcnt;
    logic kind, next_kind, tdo, next_tdo, next_prog_mode, erased, next_erased;
    logic [15:0] sr, next_sr, resp, next_resp, tdo_sr, next_tdo_sr;
    logic [3:0] instr, next_instr;
    logic [7:0] mode, next_mode, addr_lo, next_addr_lo, ee_data, next_ee_data;
    logic addr_hi, next_addr_hi, next_busy;
    logic [3:0][7:0] ee_buf, next_ee_buf;
    logic [3:0] ee_valid, next_ee_valid, ee_page, next_ee_page;
    logic [7:0] fuse_data, next_fuse_data, next_fuse_programmed;
    logic [7:0] stage, next_stage;
    logic [2:0] scnt, next_scnt;
    nvm_pkg::op_t op, next_op;
    logic [OW-1:0] opcnt, next_opcnt, op_last;
    logic [4:0] fill_ptr, next_fill_ptr;
    logic filling, next_filling;
    logic fifo_flush, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_out_data, fill_byte;
    logic [15:0] flash_word, fill_word;
    logic fl_we, ee_we;
    logic [8:0] fl_wa;
    logic [5:0] ee_wa;
    logic [7:0] ee_wd;

    assign link.tdo = tdo;

    nvm_stream_fifo #(
        .WIDTH(nvm_pkg::FIFO_WIDTH),
        .DEPTH(nvm_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .flush(fifo_flush),
        .in_valid(filling),
        .in_ready(fifo_in_ready),
        .in_data(fill_byte),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    always_comb begin
        rise = s2[2] && !d3[1] && !s2[1];
        fall = !s2[2] && d3[1] && !s2[1];
        start = !s2[1] && d3[0];
        stop = s2[1] && !d3[0];
        page_out = (instr == nvm_pkg::INSTR_PAGE_OUT) && !kind;
        flash_word = flash[{addr_hi, addr_lo}];
        fill_word = flash[{addr_hi, addr_lo[7:4], fill_ptr[4:1]}];
        fill_byte = fill_ptr[0] ? fill_word[15:8] : fill_word[7:0];
        op_last = (op == nvm_pkg::OP_ERASE) ? ERASE_LAST[OW-1:0] : WRITE_LAST[OW-1:0];
        next_bitcnt = bitcnt;
        next_kind = kind;
        next_sr = sr;
        next_instr = instr;
        next_prog_mode = prog_mode;
        next_erased = erased;
        next_mode = mode;
        next_addr_hi = addr_hi;
        next_addr_lo = addr_lo;
        next_ee_data = ee_data;
        next_ee_buf = ee_buf;
        next_ee_valid = ee_valid;
        next_ee_page = ee_page;
        next_fuse_data = fuse_data;
        next_fuse_programmed = fuse_programmed;
        next_resp = resp;
        next_tdo_sr = tdo_sr;
        next_tdo = tdo;
        next_stage = stage;
        next_scnt = scnt;
        next_op = op;
        next_opcnt = opcnt;
        next_fill_ptr = fill_ptr;
        next_filling = filling;
        fifo_flush = 1'b0;
        fifo_pop = 1'b0;
        fl_we = 1'b0;
        fl_wa = opcnt[8:0];
        ee_we = 1'b0;
        ee_wa = opcnt[5:0];
        ee_wd = nvm_pkg::ERASED_BYTE;

        if (start) begin
            next_bitcnt = 5'h00;
            next_tdo_sr = resp;
        end
        if (rise) begin
            if (bitcnt == 5'h00) begin
                next_kind = s2[0];
            end else begin
                next_sr = {s2[0], sr[15:1]};
            end
            if (bitcnt != 5'h1F) begin
                next_bitcnt = bitcnt + 5'h01;
            end
        end
        if (fall && bitcnt != 5'h00) begin
            if (page_out) begin
                // stage starts empty: first byte out is dummy
                next_tdo = stage[0];
                next_stage = {1'b0, stage[7:1]};
                next_scnt = scnt + 3'h1;
                if (scnt == 3'h7) begin
                    next_stage = fifo_out_valid ? fifo_out_data : 8'h00;
                    fifo_pop = fifo_out_valid;
                end
            end else begin
                next_tdo = tdo_sr[0];
                next_tdo_sr = {1'b0, tdo_sr[15:1]};
            end
        end
        if (stop && kind) begin
            next_instr = sr[15:12];
            if (sr[15:12] == nvm_pkg::INSTR_PAGE_OUT && prog_mode
                && mode == nvm_pkg::CMD_FL_RD_EN) begin
                fifo_flush = 1'b1;
                next_filling = 1'b1;
                next_fill_ptr = 5'h00;
                next_stage = 8'h00;
                next_scnt = 3'h0;
            end
        end
        // page-in frames carry nothing into the eeprom
        if (stop && !kind && instr == nvm_pkg::INSTR_KEY) begin
            next_prog_mode = (sr == nvm_pkg::PROG_KEY);
            if (sr != nvm_pkg::PROG_KEY) begin
                next_mode = nvm_pkg::CMD_NONE;
                next_erased = 1'b0;
            end
        end
        if (stop && !kind && instr == nvm_pkg::INSTR_CMD && prog_mode) begin
            case (sr[15:8])
                nvm_pkg::CMD_ERASE: begin
                    if (op == nvm_pkg::OP_NONE) begin
                        next_op = nvm_pkg::OP_ERASE;
                        next_opcnt = '0;
                    end
                end
                nvm_pkg::CMD_ERASE_POLL, nvm_pkg::CMD_EE_POLL, nvm_pkg::CMD_FUSE_POLL: begin
                    next_resp = {15'h0000, op == nvm_pkg::OP_NONE};
                end
                nvm_pkg::CMD_FL_RD_EN, nvm_pkg::CMD_EE_RD_EN, nvm_pkg::CMD_FUSE_WR_EN: begin
                    next_mode = sr[15:8];
                end
                nvm_pkg::CMD_EE_WR_EN: begin
                    next_mode = sr[15:8];
                    next_ee_valid = 4'h0;
                end
                nvm_pkg::CMD_FL_ADDR_HI, nvm_pkg::CMD_EE_ADDR_HI: begin
                    next_addr_hi = sr[0];
                end
                nvm_pkg::CMD_FL_ADDR_LO, nvm_pkg::CMD_EE_ADDR_LO,
                nvm_pkg::CMD_EE_RD_ADDR: begin
                    next_addr_lo = sr[7:0];
                end
                nvm_pkg::CMD_FL_READ: begin
                    if (mode == nvm_pkg::CMD_FL_RD_EN) begin
                        next_resp = flash_word;
                    end
                end
                nvm_pkg::CMD_EE_DATA: begin
                    next_ee_data = sr[7:0];
                end
                nvm_pkg::CMD_EE_LATCH: begin
                    if (op == nvm_pkg::OP_NONE) begin
                        next_ee_buf[addr_lo[1:0]] = ee_data;
                        next_ee_valid[addr_lo[1:0]] = 1'b1;
                    end
                end
                nvm_pkg::CMD_EE_WRITE: begin
                    if (mode == nvm_pkg::CMD_EE_WR_EN && erased
                        && op == nvm_pkg::OP_NONE) begin
                        next_op = nvm_pkg::OP_EE_WRITE;
                        next_opcnt = '0;
                        next_ee_page = addr_lo[5:2];
                    end
                end
                nvm_pkg::CMD_EE_READ: begin
                    if (mode == nvm_pkg::CMD_EE_RD_EN) begin
                        next_resp = {8'h00, eeprom[addr_lo[5:0]]};
                    end
                end
                nvm_pkg::CMD_FUSE_DATA: begin
                    next_fuse_data = sr[7:0];
                end
                nvm_pkg::CMD_FUSE_WRITE: begin
                    if (mode == nvm_pkg::CMD_FUSE_WR_EN && op == nvm_pkg::OP_NONE) begin
                        next_op = nvm_pkg::OP_FUSE;
                        next_opcnt = '0;
                    end
                end
                default: begin
                end
            endcase
        end

        // page fill stalls on a full buffer; a fresh page selection restarts it
        if (filling && fifo_in_ready && !fifo_flush) begin
            next_fill_ptr = fill_ptr + 5'h01;
            if (fill_ptr == 5'h1F) begin
                next_filling = 1'b0;
            end
        end

        case (op)
            nvm_pkg::OP_ERASE: begin
                fl_we = (opcnt < OW'(nvm_pkg::FLASH_WORDS));
                ee_we = (opcnt < OW'(nvm_pkg::EE_BYTES));
            end
            nvm_pkg::OP_EE_WRITE: begin
                ee_we = (opcnt < OW'(nvm_pkg::EE_PAGE_BYTES)) && ee_valid[opcnt[1:0]];
                ee_wa = {ee_page, opcnt[1:0]};
                ee_wd = ee_buf[opcnt[1:0]];
            end
            default: begin
            end
        endcase
        if (op != nvm_pkg::OP_NONE) begin
            next_opcnt = opcnt + 1'b1;
            if (opcnt == op_last) begin
                next_op = nvm_pkg::OP_NONE;
                if (op == nvm_pkg::OP_FUSE) begin
                    next_fuse_programmed = ~fuse_data;
                end
                if (op == nvm_pkg::OP_ERASE) begin
                    next_erased = 1'b1;
                end
                if (op == nvm_pkg::OP_EE_WRITE) begin
                    next_ee_valid = 4'h0;
                end
            end
        end
        next_busy = (next_op != nvm_pkg::OP_NONE);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // idle link level: tck low, tms high, so no false edge after reset
            s1 <= 3'h2;
            s2 <= 3'h2;
            d3 <= 2'h1;
            bitcnt <= 5'h00;
            kind <= 1'b0;
            sr <= 16'h0000;
            instr <= nvm_pkg::INSTR_CMD;
            prog_mode <= 1'b0;
            erased <= 1'b0;
            mode <= nvm_pkg::CMD_NONE;
            addr_hi <= 1'b0;
            addr_lo <= 8'h00;
            ee_data <= 8'h00;
            ee_buf <= '0;
            ee_valid <= 4'h0;
            ee_page <= 4'h0;
            fuse_data <= nvm_pkg::FUSE_DATA_RESET;
            fuse_programmed <= nvm_pkg::FUSE_PROG_RESET;
            resp <= 16'h0000;
            tdo_sr <= 16'h0000;
            tdo <= 1'b0;
            stage <= 8'h00;
            scnt <= 3'h0;
            op <= nvm_pkg::OP_NONE;
            opcnt <= '0;
            fill_ptr <= 5'h00;
            filling <= 1'b0;
            busy <= 1'b0;
        end else begin
            s1 <= {link.tck, link.tms, link.tdi};
            s2 <= s1;
            d3 <= s2[2:1];
            bitcnt <= next_bitcnt;
            kind <= next_kind;
            sr <= next_sr;
            instr <= next_instr;
            prog_mode <= next_prog_mode;
            erased <= next_erased;
            mode <= next_mode;
            addr_hi <= next_addr_hi;
            addr_lo <= next_addr_lo;
            ee_data <= next_ee_data;
            ee_buf <= next_ee_buf;
            ee_valid <= next_ee_valid;
            ee_page <= next_ee_page;
            fuse_data <= next_fuse_data;
            fuse_programmed <= next_fuse_programmed;
            resp <= next_resp;
            tdo_sr <= next_tdo_sr;
            tdo <= next_tdo;
            stage <= next_stage;
            scnt <= next_scnt;
            op <= next_op;
            opcnt <= next_opcnt;
            fill_ptr <= next_fill_ptr;
            filling <= next_filling;
            busy <= next_busy;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (fl_we) begin
            flash[fl_wa] <= nvm_pkg::ERASED_WORD;
        end
        if (ee_we) begin
            eeprom[ee_wa] <= ee_wd;
        end
    end
endmodule
`default_nettype wire

// file: rtl/nvm_pkg.sv
package nvm_pkg;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCK_PERIOD_NS = 160;
    localparam int TCK_HALF_CYCLES = TCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int ERASE_TIME_US = 9000;
    localparam int WRITE_TIME_US = 4000;
    // least times, rounded up to whole cycles
    localparam int ERASE_CYCLES = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OPCNT_W = 20;

    // memory geometry
    localparam int FLASH_WORDS = 512;
    localparam int EE_BYTES = 64;
    localparam int EE_PAGE_BYTES = 4;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 32;

    // test-port instructions, 4 bits
    localparam logic [3:0] INSTR_KEY = 4'h4;
    localparam logic [3:0] INSTR_CMD = 4'h5;
    localparam logic [3:0] INSTR_PAGE_IN = 4'h6;
    localparam logic [3:0] INSTR_PAGE_OUT = 4'h7;
    localparam logic [15:0] PROG_KEY = 16'hA370;

    // command opcodes, upper byte of a 16-bit command word
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h1A;
    localparam logic [7:0] CMD_ERASE_POLL = 8'h1B;
    localparam logic [7:0] CMD_FL_RD_EN = 8'h3A;
    localparam logic [7:0] CMD_FL_ADDR_HI = 8'h3B;
    localparam logic [7:0] CMD_FL_ADDR_LO = 8'h3C;
    localparam logic [7:0] CMD_FL_READ = 8'h3D;
    localparam logic [7:0] CMD_EE_WR_EN = 8'h4A;
    localparam logic [7:0] CMD_EE_ADDR_HI = 8'h4B;
    localparam logic [7:0] CMD_EE_ADDR_LO = 8'h4C;
    localparam logic [7:0] CMD_EE_DATA = 8'h4D;
    localparam logic [7:0] CMD_EE_LATCH = 8'h4E;
    localparam logic [7:0] CMD_EE_WRITE = 8'h4F;
    localparam logic [7:0] CMD_EE_POLL = 8'h47;
    localparam logic [7:0] CMD_EE_RD_EN = 8'h5A;
    localparam logic [7:0] CMD_EE_RD_ADDR = 8'h5B;
    localparam logic [7:0] CMD_EE_READ = 8'h5D;
    localparam logic [7:0] CMD_FUSE_WR_EN = 8'h6A;
    localparam logic [7:0] CMD_FUSE_DATA = 8'h6B;
    localparam logic [7:0] CMD_FUSE_WRITE = 8'h6C;
    localparam logic [7:0] CMD_FUSE_POLL = 8'h6D;

    // reset and erased values
    localparam logic [15:0] ERASED_WORD = 16'hFFFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] FUSE_DATA_RESET = 8'hFF;
    localparam logic [7:0] FUSE_PROG_RESET = 8'h00;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_ERASE = 2'b01,
        OP_EE_WRITE = 2'b11,
        OP_FUSE = 2'b10
    } op_t;

    typedef enum logic [2:0] {
        LS_IDLE = 3'b000,
        LS_LOW = 3'b001,
        LS_HIGH = 3'b011,
        LS_TAIL = 3'b010,
        LS_DONE = 3'b110
    } link_state_t;

endpackage

// file: rtl/nvm_programmer_end.sv
`timescale 1ns/1ns
`default_nettype none
module nvm_programmer_end (
    input wire logic sys_clk,
    input wire logic rst_n,
    jtag_link_if.programmer link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_instr,
    input wire logic [4:0] req_len,
    input wire logic [15:0] req_data,
    output logic rsp_valid,
    output logic [15:0] rsp_data
);
    localparam int HALF_LAST = nvm_pkg::TCK_HALF_CYCLES - 1;

    nvm_pkg::link_state_t state, next_state;
    logic [3:0] hcnt, next_hcnt;
    logic [5:0] bits, next_bits;
    logic [16:0] sh, next_sh;
    logic first, next_first;
    logic tck, next_tck, tms, next_tms, tdi, next_tdi;
    logic next_req_ready, next_rsp_valid;
    logic [15:0] next_rsp_data;
    logic tdo_s1, tdo_s2, half_done;

    assign link.tck = tck;
    assign link.tms = tms;
    assign link.tdi = tdi;

    always_comb begin
        half_done = (hcnt == HALF_LAST[3:0]);
        next_state = state;
        next_hcnt = half_done ? 4'h0 : hcnt + 4'h1;
        next_bits = bits;
        next_sh = sh;
        next_first = first;
        next_tck = tck;
        next_tms = tms;
        next_tdi = tdi;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        case (state)
            nvm_pkg::LS_IDLE: begin
                next_hcnt = 4'h0;
                next_req_ready = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_sh = {req_data, req_instr};
                    next_bits = {1'b0, req_len} + 6'h01;
                    next_first = 1'b1;
                    next_tms = 1'b0;
                    next_rsp_data = 16'h0000;
                    next_state = nvm_pkg::LS_LOW;
                end
            end
            nvm_pkg::LS_LOW: begin
                next_tdi = sh[0];
                if (half_done) begin
                    next_tck = 1'b1;
                    next_state = nvm_pkg::LS_HIGH;
                end
            end
            nvm_pkg::LS_HIGH: begin
                if (half_done) begin
                    if (!first) begin
                        // lsb first; dummy page bits left to the user
                        next_rsp_data = {tdo_s2, rsp_data[15:1]};
                    end
                    next_first = 1'b0;
                    next_sh = {1'b0, sh[16:1]};
                    next_bits = bits - 6'h01;
                    if (bits == 6'h01) begin
                        next_tms = 1'b1;
                        next_state = nvm_pkg::LS_TAIL;
                    end else begin
                        next_tck = 1'b0;
                        next_state = nvm_pkg::LS_LOW;
                    end
                end
            end
            nvm_pkg::LS_TAIL: begin
                // tms rises while tck is high so the device sees no extra bit
                if (half_done) begin
                    next_tck = 1'b0;
                    next_state = nvm_pkg::LS_DONE;
                end
            end
            nvm_pkg::LS_DONE: begin
                next_rsp_valid = 1'b1;
                next_state = nvm_pkg::LS_IDLE;
            end
            default: begin
                next_state = nvm_pkg::LS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= nvm_pkg::LS_IDLE;
            hcnt <= 4'h0;
            bits <= 6'h00;
            sh <= 17'h00000;
            first <= 1'b0;
            tck <= 1'b0;
            tms <= 1'b1;
            tdi <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 16'h0000;
            tdo_s1 <= 1'b0;
            tdo_s2 <= 1'b0;
        end else begin
            state <= next_state;
            hcnt <= next_hcnt;
            bits <= next_bits;
            sh <= next_sh;
            first <= next_first;
            tck <= next_tck;
            tms <= next_tms;
            tdi <= next_tdi;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            tdo_s1 <= link.tdo;
            tdo_s2 <= tdo_s1;
        end
    end
endmodule
`default_nettype wire

// file: test/jtag_nvm_program_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
module jtag_nvm_program_sequencer_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_instr = 1'b0;
    logic [4:0] req_len = 5'h00;
    logic [15:0] req_data = 16'h0000;
    logic req_ready, rsp_valid, prog_mode, busy;
    logic [15:0] rsp_data;
    logic [7:0] fuse_programmed;
    logic [38:0] rows [28];
    int bad_count = 0;
    int total_checks = 0;
    logic no_wait = 1'b0;
    jtag_link_if link();
    always #5 sys_clk = ~sys_clk;
    nvm_device_end #(.ERASE_CYCLES(600), .WRITE_CYCLES(20)) u_nvm_device_end (.sys_clk(sys_clk),
        .rst_n(rst_n), .link(link), .prog_mode(prog_mode), .busy(busy),
        .fuse_programmed(fuse_programmed));
    nvm_programmer_end u_nvm_programmer_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link),
        .req_valid(req_valid), .req_ready(req_ready), .req_instr(req_instr), .req_len(req_len),
        .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    nvm_link_properties u_nvm_link_properties (.sys_clk(sys_clk), .rst_n(rst_n),
        .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo));
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one frame; waits out any erase or write it starts unless no_wait
    task frame(input logic [38:0] r);
        logic got_rsp;
        got_rsp = 1'b0;
        req_instr = r[37];
        req_len = r[36:32];
        req_data = r[31:16];
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        repeat (400) begin
            @(posedge sys_clk);
            #1;
            if (rsp_valid === 1'b1) begin
                got_rsp = 1'b1;
                break;
            end
        end
        if (!got_rsp) begin
            bad_count++;
            $display("[ERR] %0t no response to frame", $time);
        end
        repeat (8) @(posedge sys_clk);
        #1;
        while (busy === 1'b1 && !no_wait) begin
            @(posedge sys_clk);
            #1;
        end
    endtask
    initial begin
        // {check, instr, len, data, expected response}
        rows = '{39'h24_0004_0000, 39'h10_A370_0000, 39'h24_0005_0000, 39'h10_1A00_0000,
            39'h10_1B00_0000, 39'h50_3A00_0001, 39'h10_3B00_0000, 39'h10_3C05_0000,
            39'h10_3D00_0000, 39'h50_4A00_FFFF, 39'h10_4B00_0000, 39'h10_4C03_0000,
            39'h10_4D3C_0000, 39'h10_4E00_0000, 39'h10_4F00_0000, 39'h10_4700_0000,
            39'h50_5A00_0001, 39'h10_5B03_0000, 39'h10_5D00_0000, 39'h50_6A00_003C,
            39'h10_6B5A_0000, 39'h10_6C00_0000, 39'h10_6D00_0000, 39'h50_3A00_0001,
            39'h10_3B00_0000, 39'h10_3C00_0000, 39'h24_0007_0000, 39'h50_0000_FF00};
        repeat (5) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        cmp({prog_mode, busy, 6'h00, fuse_programmed}, 16'h0000);
        for (int i = 0; i < 28; i++) begin
            frame(rows[i]);
            if (rows[i][38]) cmp(rsp_data, rows[i][15:0]);
        end
        frame(39'h50_0000_FFFF);
        cmp(rsp_data, 16'hFFFF);
        cmp({8'h00, fuse_programmed}, 16'h00A5);
        cmp({15'h0000, prog_mode}, 16'h0001);
        frame(39'h24_0005_0000);
        no_wait = 1'b1;
        frame(39'h10_1A00_0000);
        frame(39'h10_1B00_0000);
        no_wait = 1'b0;
        cmp({15'h0000, busy}, 16'h0001);
        frame(39'h10_1B00_0000);
        cmp(rsp_data, 16'h0000);
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        cmp({prog_mode, busy, 6'h00, fuse_programmed}, 16'h0000);
        rst_n = 1'b1;
        frame(39'h24_0004_0000);
        frame(39'h10_A370_0000);
        cmp({15'h0000, prog_mode}, 16'h0001);
        frame(39'h24_0004_0000);
        frame(39'h10_0000_0000);
        cmp({15'h0000, prog_mode}, 16'h0000);
        test_done;
    end
    initial begin
        #500000;
        bad_count++;
        test_done;
    end
endmodule
`default_nettype wire

// file: test/nvm_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module nvm_link_properties (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_high8;
        tck [*8];
    endsequence
    sequence s_low8;
        !tck [*8];
    endsequence
    a_tck_high_len: assert property ($rose(tck) |-> s_high8)
        else $error("tck high phase wrong");
    a_tck_low_len: assert property ($fell(tck) && !tms |-> s_low8 ##1 tck)
        else $error("tck low phase wrong");
    a_tdi_steady: assert property (tck && !tms |-> $stable(tdi))
        else $error("tdi moved while tck high");
    a_tdo_steady: assert property (tck && !tms |-> $stable(tdo))
        else $error("tdo moved while tck high");
    a_tms_rise_high: assert property ($rose(tms) |-> tck)
        else $error("frame closed with tck low");
    a_frame_start_low: assert property ($fell(tms) |-> !tck)
        else $error("frame opened with tck high");
    a_tck_in_frame: assert property ($rose(tck) |-> !tms)
        else $error("tck pulse outside frame");
    a_idle_tck_low: assert property (tms [*8] ##1 tms |=> !tck)
        else $error("tck not parked low");
endmodule
`default_nettype wire
